// ===== dv/low_speed_backup_oscillator_checker.sv
// Port assertions for the oscillator block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module low_speed_backup_oscillator_checker #(
  parameter [7:0] FACTORY_CONFIG_BYTE_VALUE = 8'hff
) (
  // Clock, reset and bus
  input wire       clk_i,
  input wire       rst_i,
  input wire       ce_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire       wr_i,
  input wire       rd_i,
  input wire [7:0] rdata_o,
  // Pins and controls
  input wire       t0_pin_i,
  input wire       shared_pin_i,
  input wire       crystal_enable_o,
  input wire       fast_rc_enable_o,
  input wire       crystal_gain_select_o,
  input wire       watchdog_rc_enable_o,
  input wire       watchdog_main_clk_o,
  input wire [2:0] lock_bits_o,
  input wire       pin_reset_function_o,
  input wire       ext_reset_n_o,
  input wire       shared_pin_in_o,
  input wire       backup_active_o,
  input wire       timer0_count_o
);
  reg sel_q;
  wire ctl_wr = ce_i && wr_i && addr_i == 8'h86;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Stored Timer 0 source select
  always @(posedge clk_i)
    if (rst_i)
      sel_q <= 1'b0;
    else if (ctl_wr)
      sel_q <= wdata_i[2];
  AST_CTRL_RD: assert property (ce_i && rd_i && addr_i == 8'h86 |=> rdata_o[7:3] == 5'h00)
    else $error("control read shows reserved bits");
  AST_FACTORY_CONFIG_BYTE_RD: assert property (ce_i && rd_i && addr_i == 8'hef |=> rdata_o == (FACTORY_CONFIG_BYTE_VALUE | 8'h01))
    else $error("config read wrong");
  AST_WR_EN: assert property (ctl_wr |=> ##1 {fast_rc_enable_o, crystal_enable_o} == $past(wdata_i[1:0], 2))
    else $error("enables do not follow write");
  AST_CFG_OUT: assert property (!$past(rst_i) && !$past(rst_i, 2) |-> lock_bits_o == FACTORY_CONFIG_BYTE_VALUE[7:5]
    && crystal_gain_select_o == FACTORY_CONFIG_BYTE_VALUE[3] && pin_reset_function_o == FACTORY_CONFIG_BYTE_VALUE[2]
    && watchdog_main_clk_o == FACTORY_CONFIG_BYTE_VALUE[1] && watchdog_rc_enable_o == !FACTORY_CONFIG_BYTE_VALUE[1])
    else $error("config outputs wrong");
  AST_PIN_RISE: assert property ($rose(shared_pin_i) |-> ##[1:3] (ext_reset_n_o
    && shared_pin_in_o == !FACTORY_CONFIG_BYTE_VALUE[2]))
    else $error("shared pin rise misrouted");
  AST_PIN_FALL: assert property ($fell(shared_pin_i) |-> ##[1:3] (!shared_pin_in_o
    && ext_reset_n_o == !FACTORY_CONFIG_BYTE_VALUE[2]))
    else $error("shared pin fall misrouted");
  AST_BACKUP: assert property (ctl_wr && wdata_i[1:0] == 2'b00 |=> ##[0:2] backup_active_o)
    else $error("backup not active");
  AST_T0_PIN: assert property (!sel_q && $rose(t0_pin_i) |-> ##[3:4] timer0_count_o)
    else $error("pin edge not counted");
  AST_T0_PULSE: assert property (timer0_count_o |=> !timer0_count_o)
    else $error("count pulse too long");
endmodule // low_speed_backup_oscillator_checker

bind low_speed_backup_oscillator_top low_speed_backup_oscillator_checker #(.FACTORY_CONFIG_BYTE_VALUE(FACTORY_CONFIG_BYTE_VALUE)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .t0_pin_i(t0_pin_i), .shared_pin_i(shared_pin_i),
  .crystal_enable_o(crystal_enable_o), .fast_rc_enable_o(fast_rc_enable_o),
  .crystal_gain_select_o(crystal_gain_select_o), .watchdog_rc_enable_o(watchdog_rc_enable_o),
  .watchdog_main_clk_o(watchdog_main_clk_o), .lock_bits_o(lock_bits_o),
  .pin_reset_function_o(pin_reset_function_o), .ext_reset_n_o(ext_reset_n_o),
  .shared_pin_in_o(shared_pin_in_o), .backup_active_o(backup_active_o),
  .timer0_count_o(timer0_count_o));

// ===== dv/low_speed_backup_oscillator_osc_model.sv
// Behavioural oscillators and Timer 0 pin source.
// Assumes a stopped source rests low at once.
`timescale 1ns/1ps
module low_speed_backup_oscillator_osc_model (
  // Enables
  input  wire xtal_en_i,
  input  wire frc_en_i,
  input  wire t0_run_i,
  // Levels
  output wire xtal_o,
  output wire frc_o,
  output reg  lsrc_o,
  output wire t0_o
);
  reg xph = 1'b0;
  reg fph = 1'b0;
  reg tph = 1'b0;
  // Free phases, off the clock grid
  always #433 xph = ~xph;
  always #173 fph = ~fph;
  always #107 tph = ~tph;
  initial lsrc_o = 1'b0;
  always #1009 lsrc_o = ~lsrc_o;
  // Crystal, fast RC and pin sources run only while enabled; the backup RC always runs
  assign xtal_o = xtal_en_i & xph;
  assign frc_o  = frc_en_i & fph;
  assign t0_o   = t0_run_i & tph;
endmodule // low_speed_backup_oscillator_osc_model

// ===== dv/testbench.sv
// Self-checking bench for the oscillator block.
// Assumes a 25 MHz clock and synchronous active-high reset.
`timescale 1ns/1ps
module testbench;
  localparam [7:0] FACTORY_CONFIG_BYTE = 8'h6b; // Bit 0 left erased
  reg        clk_i = 1'b0;
  reg        rst_i = 1'b1;
  reg        ce_i = 1'b1;
  reg  [7:0] addr_i = 8'h00;
  reg  [7:0] wdata_i = 8'h00;
  reg        wr_i = 1'b0;
  reg        rd_i = 1'b0;
  reg        t0_run = 1'b0;
  reg        pin = 1'b0;
  reg        rd_d = 1'b0;
  reg  [7:0] v;
  reg  [7:0] expq[$];
  wire [7:0] rdata_o;
  wire       xen, fen, xc, fc, lc, t0, t0c, bk;
  integer    fails = 0;
  integer    compares = 0;
  integer    seed = 40;
  integer    n_t0 = 0;
  integer    n_x = 0;
  integer    n_c = 0;
  integer    i, c0, s0;
  // Clock
  always #20 clk_i = ~clk_i;
  low_speed_backup_oscillator_top #(.FACTORY_CONFIG_BYTE_VALUE(FACTORY_CONFIG_BYTE)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .xtal_clk_i(xc), .frc_clk_i(fc), .lsrc_clk_i(lc), .t0_pin_i(t0), .shared_pin_i(pin),
    .crystal_enable_o(xen), .fast_rc_enable_o(fen), .crystal_gain_select_o(),
    .watchdog_rc_enable_o(), .watchdog_main_clk_o(), .lock_bits_o(),
    .pin_reset_function_o(), .ext_reset_n_o(), .shared_pin_in_o(), .main_clk_o(),
    .backup_active_o(bk), .prescale_tick_o(), .timer0_count_o(t0c));
  low_speed_backup_oscillator_osc_model i_osc (.xtal_en_i(xen), .frc_en_i(fen), .t0_run_i(t0_run),
    .xtal_o(xc), .frc_o(fc), .lsrc_o(lc), .t0_o(t0));
  task check(input [47:0] name, input [7:0] seen, input [7:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("[ERR] %0s exp %h seen %h", name, exp, seen);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [7:0] e);
  begin
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    expq.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
  end
  endtask
  task tally_and_finish;
  begin
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // Read results are compared in the cycle they stand
  always @(posedge clk_i) rd_d <= rd_i & ce_i;
  always @(negedge clk_i)
    if (rd_d && expq.size() > 0)
      check("rdata", rdata_o, expq.pop_front());
  // Edge tallies
  always @(posedge t0) n_t0 = n_t0 + 1;
  always @(posedge xc) n_x = n_x + 1;
  always @(posedge clk_i) if (t0c === 1'b1) n_c <= n_c + 1;
  // Cuts a hang short
  initial
  begin
    #400000;
    fails = fails + 1;
    tally_and_finish;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'hef, FACTORY_CONFIG_BYTE);
    rd(8'h85, {7'h00, FACTORY_CONFIG_BYTE[4]});
    rd(8'h97, 8'hff);
    rd(8'h10, 8'h00);
    wr(8'hef, 8'h00);
    rd(8'hef, FACTORY_CONFIG_BYTE);
    wr(8'h86, 8'h07); // Reserved bits left clear
    rd(8'h86, 8'h07);
    $display("registers done");
    for (i = 0; i < 6; i = i + 1)
    begin
      v = $random(seed) & 8'h03;
      wr(8'h86, v);
      rd(8'h86, v);
      pin <= ~pin;
    end
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(8'h86, ~v & 8'h03);
    ce_i <= 1'b1;
    rd(8'h86, v);
    $display("enables done");
    wr(8'h86, 8'h02);
    c0 = n_c;
    s0 = n_t0;
    t0_run <= 1'b1;
    repeat (200) @(posedge clk_i);
    t0_run <= 1'b0;
    repeat (10) @(posedge clk_i);
    check("t0pin", n_c - c0, n_t0 - s0);
    wr(8'h97, 8'hff);
    wr(8'h86, 8'h06);
    repeat (6) @(posedge clk_i);
    c0 = n_c;
    s0 = n_x;
    t0_run <= 1'b1;
    wr(8'h86, 8'h07);
    repeat (300) @(posedge clk_i);
    wr(8'h86, 8'h06);
    t0_run <= 1'b0;
    repeat (10) @(posedge clk_i);
    check("t0sub", n_c - c0, n_x - s0);
    $display("timer source done");
    wr(8'h86, 8'h00);
    repeat (3) @(posedge clk_i);
    check("bkup", {7'h00, bk}, 8'h01);
    wr(8'h86, 8'h02);
    repeat (3) @(posedge clk_i);
    check("bkup", {7'h00, bk}, 8'h00);
    $display("backup done");
    tally_and_finish;
  end
endmodule // testbench

// ===== hdl/low_speed_backup_oscillator_consts.vh
// Constants for the oscillator configuration and Timer 0 sub clock block.
// Assumes a single 25 MHz clock and a plain strobe register port.
// What this block does
// - Control bit 2 picks Timer 0 count source: 0 pin, 1 sub clock.
// - Control bit 1 enables fast RC, bit 0 enables crystal; 1 runs.
// - Reset clears bit 7 and sub clock select; enables follow reset-osc bit.
// - Configuration byte is readable, read-only; writes never alter it.
// - Configuration bits 7..5 are program memory lock bits.
// - Config bit 4 picks reset oscillator: 1 crystal, 0 RC if watchdog RC off.
// - Config bit 3 picks crystal gain: 1 high speed, 0 low power 32 kHz.
// - Config bit 2: 1 shared pin is active-low reset, 0 plain input.
// - Config bit 1: 1 watchdog RC off, main clock; 0 watchdog RC runs.
// - Erased configuration byte reads ones in bits 7..1.
// - Main clock select switches crystal and fast RC without glitches.
// - With both oscillators disabled, low speed backup RC clocks the core.
// - Prescale reload all ones divides by 2, all zeros by 512.
`ifndef LOW_SPEED_BACKUP_OSCILLATOR_CONSTS_VH
`define LOW_SPEED_BACKUP_OSCILLATOR_CONSTS_VH

`define LOW_SPEED_BACKUP_OSCILLATOR_ADDR_CTRL       8'h86
`define LOW_SPEED_BACKUP_OSCILLATOR_ADDR_FACTORY_CONFIG_BYTE       8'hef
`define LOW_SPEED_BACKUP_OSCILLATOR_ADDR_CKSEL      8'h85
`define LOW_SPEED_BACKUP_OSCILLATOR_ADDR_RELOAD     8'h97

`define LOW_SPEED_BACKUP_OSCILLATOR_CTRL_XTAL_BIT   0
`define LOW_SPEED_BACKUP_OSCILLATOR_CTRL_FRC_BIT    1
`define LOW_SPEED_BACKUP_OSCILLATOR_CTRL_T0SUB_BIT  2

`define LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_LOCK_MSB   7
`define LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_LOCK_LSB   5
`define LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_RSTOSC_BIT 4
`define LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_GAIN_BIT   3
`define LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_PINRST_BIT 2
`define LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_WATCHDOG_RC_OSCILLATOR_BIT   1

`define LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_ERASED     8'hff
`define LOW_SPEED_BACKUP_OSCILLATOR_RELOAD_RESET    8'hff
`define LOW_SPEED_BACKUP_OSCILLATOR_SWITCH_SETTLE   4

`endif

// ===== hdl/low_speed_backup_oscillator_sync.v
// Two-flop synchroniser for a group of single-bit levels.
// Assumes inputs may be asynchronous to clk_i; clock enable freezes it.
`timescale 1ns/1ps
module low_speed_backup_oscillator_sync #(
  parameter WIDTH = 2
) (
  // Clock, reset and enable
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  // Levels
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // One generate lane per bit; the first flop feeds only the second
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_lane
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end
        else if (ce_i)
        begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;

endmodule // low_speed_backup_oscillator_sync

// ===== hdl/low_speed_backup_oscillator_top.v
// Oscillator enable control, configuration byte view, clock select and
// Timer 0 count source selection.
// Assumes oscillator clocks arrive as plain levels sampled on clk_i.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "low_speed_backup_oscillator_consts.vh"
module low_speed_backup_oscillator_top #(
  parameter [7:0] FACTORY_CONFIG_BYTE_VALUE = `LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_ERASED,
  parameter       SETTLE     = `LOW_SPEED_BACKUP_OSCILLATOR_SWITCH_SETTLE
) (
  // Clock, reset and enable
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  // Register port
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output reg  [7:0] rdata_o,
  // Oscillator levels
  input  wire       xtal_clk_i,
  input  wire       frc_clk_i,
  input  wire       lsrc_clk_i,
  input  wire       t0_pin_i,
  input  wire       shared_pin_i,
  // Oscillator controls
  output reg        crystal_enable_o,
  output reg        fast_rc_enable_o,
  output reg        crystal_gain_select_o,
  output reg        watchdog_rc_enable_o,
  output reg        watchdog_main_clk_o,
  output reg  [2:0] lock_bits_o,
  // Pin function
  output reg        pin_reset_function_o,
  output reg        ext_reset_n_o,
  output reg        shared_pin_in_o,
  // Clocking outputs
  output reg        main_clk_o,
  output reg        backup_active_o,
  output reg        prescale_tick_o,
  output reg        timer0_count_o
);

  // Control register fields
  reg        crystal_enable_q;
  reg        fast_rc_enable_q;
  reg        timer0_subclock_select_q;
  reg        main_clock_select_q;
  reg  [7:0] clock_prescale_reload_q;

  // Configuration fields, fixed by mask
  wire       rst_osc   = FACTORY_CONFIG_BYTE_VALUE[`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_RSTOSC_BIT];
  wire       watchdog_rc_oscillator_off  = FACTORY_CONFIG_BYTE_VALUE[`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_WATCHDOG_RC_OSCILLATOR_BIT];
  wire [7:0] factory_config_byte_view = {FACTORY_CONFIG_BYTE_VALUE[7:1], 1'b1};

  // Synchronised oscillator levels and timer pin
  wire [3:0] sync_w;
  wire       xtal_s = sync_w[0];
  wire       frc_s  = sync_w[1];
  wire       lsrc_s = sync_w[2];
  wire       t0p_s  = sync_w[3];

  low_speed_backup_oscillator_sync #(
    .WIDTH   (4)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i ({t0_pin_i, lsrc_clk_i, frc_clk_i, xtal_clk_i}),
    .sync_o  (sync_w)
  );

  // Register writes; configuration byte ignores writes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer0_subclock_select_q <= 1'b0;
      crystal_enable_q         <= rst_osc;
      fast_rc_enable_q         <= ~rst_osc & watchdog_rc_oscillator_off;
      main_clock_select_q      <= rst_osc;
      clock_prescale_reload_q  <= `LOW_SPEED_BACKUP_OSCILLATOR_RELOAD_RESET;
    end
    else if (ce_i)
    begin
      if (wr_i && addr_i == `LOW_SPEED_BACKUP_OSCILLATOR_ADDR_CTRL)
      begin
        crystal_enable_q         <= wdata_i[`LOW_SPEED_BACKUP_OSCILLATOR_CTRL_XTAL_BIT];
        fast_rc_enable_q         <= wdata_i[`LOW_SPEED_BACKUP_OSCILLATOR_CTRL_FRC_BIT];
        timer0_subclock_select_q <= wdata_i[`LOW_SPEED_BACKUP_OSCILLATOR_CTRL_T0SUB_BIT];
      end
      else if (wr_i && addr_i == `LOW_SPEED_BACKUP_OSCILLATOR_ADDR_CKSEL)
        main_clock_select_q <= wdata_i[0];
      else if (wr_i && addr_i == `LOW_SPEED_BACKUP_OSCILLATOR_ADDR_RELOAD)
        clock_prescale_reload_q <= wdata_i;
    end
  end

  // Reset loads oscillator enables from the reset-oscillator bit
  reg init_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
      init_q <= 1'b1;
    else if (ce_i)
      init_q <= 1'b0;
  end

  // Effective enables: first cycle after reset follows configuration
  wire xen = init_q ? rst_osc : crystal_enable_q;
  wire fen = init_q ? (~rst_osc & watchdog_rc_oscillator_off) : fast_rc_enable_q;
  wire sel = init_q ? rst_osc : main_clock_select_q;
  reg  xen_hold_q;
  reg  fen_hold_q;
  reg  sel_hold_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xen_hold_q <= 1'b0;
      fen_hold_q <= 1'b0;
      sel_hold_q <= 1'b0;
    end
    else if (ce_i && init_q)
    begin
      xen_hold_q <= rst_osc;
      fen_hold_q <= ~rst_osc & watchdog_rc_oscillator_off;
      sel_hold_q <= rst_osc;
    end
  end

  // Glitch-free select: change only when both sources are low
  reg       sel_live_q;
  reg [2:0] settle_q;
  wire      both_low = ~xtal_s & ~frc_s;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_live_q <= 1'b0;
      settle_q   <= 3'h0;
    end
    else if (ce_i)
    begin
      if (sel != sel_live_q && both_low)
      begin
        sel_live_q <= sel;
        settle_q   <= SETTLE[2:0];
      end
      else if (settle_q != 3'h0)
        settle_q <= settle_q - 3'h1;
    end
  end

  // Main clock source with low speed backup
  wire backup = ~xen & ~fen;
  wire src_clk = backup ? lsrc_s : (sel_live_q ? xtal_s : frc_s);

  // Prescaler: toggles every (256 - reload) source edges
  reg       src_q;
  reg [7:0] pre_cnt_q;
  reg       pre_clk_q;
  wire      src_rise = src_clk & ~src_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      src_q     <= 1'b0;
      pre_cnt_q <= 8'h00;
      pre_clk_q <= 1'b0;
    end
    else if (ce_i)
    begin
      src_q <= src_clk;
      if (src_rise && settle_q == 3'h0)
      begin
        if (pre_cnt_q == 8'hff)
        begin
          pre_cnt_q <= clock_prescale_reload_q; // 256-M edges per half period
          pre_clk_q <= ~pre_clk_q;
        end
        else
          pre_cnt_q <= pre_cnt_q + 8'h01;
      end
    end
  end

  // Timer 0 source: sub clock from crystal, pin otherwise
  reg t0_sel_q;
  reg t0_src_q;
  wire t0_src = t0_sel_q ? xtal_s : t0p_s;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      t0_sel_q <= 1'b0;
      t0_src_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (timer0_subclock_select_q != t0_sel_q && ~xtal_s && ~t0p_s)
        t0_sel_q <= timer0_subclock_select_q;
      t0_src_q <= t0_src;
    end
  end

  // Read data, one cycle after the read strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (ce_i)
    begin
      if (rd_i && addr_i == `LOW_SPEED_BACKUP_OSCILLATOR_ADDR_CTRL)
        rdata_o <= {5'h00, timer0_subclock_select_q, fen, xen};
      else if (rd_i && addr_i == `LOW_SPEED_BACKUP_OSCILLATOR_ADDR_FACTORY_CONFIG_BYTE)
        rdata_o <= factory_config_byte_view;
      else if (rd_i && addr_i == `LOW_SPEED_BACKUP_OSCILLATOR_ADDR_CKSEL)
        rdata_o <= {7'h00, sel};
      else if (rd_i && addr_i == `LOW_SPEED_BACKUP_OSCILLATOR_ADDR_RELOAD)
        rdata_o <= clock_prescale_reload_q;
      else
        rdata_o <= 8'h00;
    end
  end

  // Registered control outputs
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      crystal_enable_o      <= 1'b0;
      fast_rc_enable_o      <= 1'b0;
      crystal_gain_select_o <= 1'b0;
      watchdog_rc_enable_o  <= 1'b0;
      watchdog_main_clk_o   <= 1'b0;
      lock_bits_o           <= 3'h0;
      pin_reset_function_o  <= 1'b0;
      ext_reset_n_o         <= 1'b1;
      shared_pin_in_o       <= 1'b0;
      main_clk_o            <= 1'b0;
      backup_active_o       <= 1'b0;
      prescale_tick_o       <= 1'b0;
      timer0_count_o        <= 1'b0;
    end
    else if (ce_i)
    begin
      crystal_enable_o      <= xen;
      fast_rc_enable_o      <= fen;
      crystal_gain_select_o <= FACTORY_CONFIG_BYTE_VALUE[`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_GAIN_BIT];
      watchdog_rc_enable_o  <= ~watchdog_rc_oscillator_off;
      watchdog_main_clk_o   <= watchdog_rc_oscillator_off;
      lock_bits_o <= FACTORY_CONFIG_BYTE_VALUE[`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_LOCK_MSB:`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_LOCK_LSB];
      pin_reset_function_o  <= FACTORY_CONFIG_BYTE_VALUE[`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_PINRST_BIT];
      ext_reset_n_o   <= FACTORY_CONFIG_BYTE_VALUE[`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_PINRST_BIT] ? shared_pin_i : 1'b1;
      shared_pin_in_o <= FACTORY_CONFIG_BYTE_VALUE[`LOW_SPEED_BACKUP_OSCILLATOR_FACTORY_CONFIG_BYTE_PINRST_BIT] ? 1'b0 : shared_pin_i;
      main_clk_o            <= pre_clk_q;
      backup_active_o       <= backup;
      prescale_tick_o <= src_rise && settle_q == 3'h0 &&
                         pre_cnt_q == 8'hff;
      timer0_count_o <= t0_src & ~t0_src_q;  // One pulse per rising source edge
    end
  end

  // Hold copies of the reset-time choice feed only an unused wire; no read shows them
  wire unused_hold = xen_hold_q ^ fen_hold_q ^ sel_hold_q;

endmodule // low_speed_backup_oscillator_top
